// ### dv/memory_region_decoder_tb_top.sv
`timescale 1ns/10ps
module memory_region_decoder_tb_top;
	import mrd_pkg::*;
	logic CLK = 0, RST_B = 0, ISRAM_EN = 1, CACHE_EN = 0, PARITY_EN = 0;
	logic HIB_ENTER = 0, HIB_ISRAM_KEEP = 0, HIB_WAKE = 0;
	logic REQ, REQ_DMA, REQ_WRITE, RSP_VALID, RSP_ERROR, FWD_VALID, FWD_WRITE;
	logic PARITY_ERR, CACHE_INVALID;
	logic [1:0] REQ_SIZE, HIB_KEEP_MAP;
	logic [3:0] FWD_TARGET, FWD_STRB;
	logic [31:0] REQ_ADDR, REQ_WDATA, RSP_RDATA, FWD_ADDR, FWD_WDATA;
	int n_fail = 0, tests_run = 0, cyc = 0;
	localparam logic [2:0] OK = 3'b100, ER = 3'b110, FW = 3'b001;
	mrd_decoder dut (.*);
	mrd_master_model u_mst (.*);
	always #5 CLK = ~CLK;
	// hang guard, whole run is under a hundred cycles
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic route(input logic d, input logic [31:0] a, input logic [2:0] ve,
		input logic [3:0] t);
		u_mst.go(d, 1'b0, MRD_SZ_WORD, a, 32'h0);
		chk({29'h0, RSP_VALID, RSP_ERROR, FWD_VALID}, {29'h0, ve});
		if (ve[0]) chk({28'h0, FWD_TARGET}, {28'h0, t});
	endtask : route
	// core word write, dma write of size s on top, read back merged
	task automatic merge(input logic [31:0] a, w0, input logic [1:0] s, input logic [31:0] a1,
		w1, exp);
		u_mst.go(1'b0, 1'b1, MRD_SZ_WORD, a, w0);
		u_mst.go(1'b1, 1'b1, s, a1, w1);
		u_mst.go(1'b1, 1'b0, MRD_SZ_WORD, a, 32'h0);
		chk(RSP_RDATA, exp);
		chk({30'h0, RSP_ERROR, PARITY_ERR}, 32'h0);
	endtask : merge
	task automatic t_map();
		route(1'b0, 32'h0000_0000, FW, MRD_T_FLASH);
		route(1'b0, 32'h0007_f000, FW, MRD_T_KEY);
		route(1'b0, 32'h0008_0000, ER, 4'h0);
		route(1'b1, 32'h1000_0000, OK, 4'h0);
		route(1'b0, 32'h1000_8000, ER, 4'h0);
		route(1'b0, 32'h2000_4000, ER, 4'h0);
		route(1'b1, 32'h2004_0000, OK, 4'h0);
		route(1'b1, 32'h2004_7ffc, OK, 4'h0);
		route(1'b0, 32'h4000_0000, FW, MRD_T_MMR);
		route(1'b0, 32'he000_0000, FW, MRD_T_PPB);
		route(1'b1, 32'he003_fffc, ER, 4'h0);
		route(1'b0, 32'he004_0000, FW, MRD_T_PLAT);
		route(1'b1, 32'he004_0000, ER, 4'h0);
		route(1'b0, 32'hffff_fffc, FW, MRD_T_SYS);
	endtask : t_map
	task automatic t_sram();
		@(posedge CLK);
		PARITY_EN <= 1'b1;
		merge(32'h2000_0000, 32'ha5a5_1234, MRD_SZ_WORD, 32'h2000_0000, 32'h0bad_f00d,
			32'h0bad_f00d);
		merge(32'h2004_8000, 32'h1122_3344, MRD_SZ_BYTE, 32'h2004_8002, 32'h00cc_0000,
			32'h11cc_3344);
		merge(32'h2005_0000, 32'h5566_7788, MRD_SZ_HALF, 32'h2005_0002, 32'hbeef_0000,
			32'hbeef_7788);
		@(posedge CLK);
		PARITY_EN <= 1'b0;
	endtask : t_sram
	// forwarded byte write keeps address, data and lanes
	task automatic t_fwd();
		u_mst.go(1'b0, 1'b1, MRD_SZ_BYTE, 32'h4000_0001, 32'h0000_ab00);
		chk({29'h0, RSP_VALID, FWD_VALID, FWD_WRITE}, 32'h3);
		chk(FWD_ADDR, 32'h4000_0001);
		chk(FWD_WDATA, 32'h0000_ab00);
		chk({28'h0, FWD_STRB}, 32'h2);
	endtask : t_fwd
	task automatic t_modes();
		@(posedge CLK);
		ISRAM_EN <= 1'b0;
		route(1'b0, 32'h2005_4000, OK, 4'h0);
		route(1'b1, 32'h2005_bffc, OK, 4'h0);
		route(1'b0, 32'h2005_c000, ER, 4'h0);
		route(1'b0, 32'h1000_0000, ER, 4'h0);
		@(posedge CLK);
		ISRAM_EN <= 1'b1;
		CACHE_EN <= 1'b1;
		route(1'b0, 32'h1000_6ffc, OK, 4'h0);
		route(1'b0, 32'h1000_7000, ER, 4'h0);
	endtask : t_modes
	// retention layout latch, then wake with cache still enabled
	task automatic t_hib();
		for (int k = 0; k < 2; k++) begin
			@(posedge CLK);
			HIB_ISRAM_KEEP <= k[0];
			HIB_ENTER      <= 1'b1;
			@(posedge CLK);
			HIB_ENTER <= 1'b0;
			#1 chk({30'h0, HIB_KEEP_MAP}, k + 1);
		end
		@(posedge CLK);
		HIB_WAKE <= 1'b1;
		@(posedge CLK);
		HIB_WAKE <= 1'b0;
		#1 chk({31'h0, CACHE_INVALID}, 32'h1);
		@(posedge CLK);
		CACHE_EN <= 1'b0;
		repeat (2) @(posedge CLK);
		#1 chk({31'h0, CACHE_INVALID}, 32'h0);
	endtask : t_hib
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	initial begin
		repeat (3) @(posedge CLK);
		RST_B <= 1'b1;
		t_map();
		t_sram();
		t_fwd();
		t_modes();
		t_hib();
		finish_test();
	end
endmodule : memory_region_decoder_tb_top
bind mrd_decoder mrd_checker u_chk (.*);

// ### dv/mrd_checker.sv
`timescale 1ns/10ps
module mrd_checker
	import mrd_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic        REQ,
	input wire logic        REQ_DMA,
	input wire logic [31:0] REQ_ADDR,
	input wire logic        CACHE_EN,
	input wire logic        HIB_WAKE,
	input wire logic        RSP_VALID,
	input wire logic        RSP_ERROR,
	input wire logic        FWD_VALID,
	input wire logic [3:0]  FWD_TARGET,
	input wire logic        PARITY_ERR,
	input wire logic        CACHE_INVALID
);
	// ****************************************************************
	// access answers and cache invalid flag
	// ****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	a_one_answer: assert property (REQ |=> RSP_VALID ^ FWD_VALID)
		else $error("request not answered exactly once");
	a_dma_sys_refused: assert property (REQ && REQ_DMA && REQ_ADDR >= MRD_SYS_BASE
		|=> RSP_VALID && RSP_ERROR) else $error("dma system access not refused");
	a_core_ppb: assert property (REQ && !REQ_DMA && REQ_ADDR >= MRD_SYS_BASE
		&& REQ_ADDR < MRD_PPB_END |=> FWD_TARGET == MRD_T_PPB) else $error("ppb misrouted");
	a_core_plat: assert property (REQ && !REQ_DMA && REQ_ADDR >= MRD_PLAT_BASE
		&& REQ_ADDR < MRD_PLAT_END |=> FWD_TARGET == MRD_T_PLAT) else $error("plat misrouted");
	a_key_window: assert property (REQ && REQ_ADDR >= MRD_KEY_BASE
		&& REQ_ADDR <= MRD_CODE_LAST |=> FWD_VALID && FWD_TARGET == MRD_T_KEY)
		else $error("key window misrouted");
	a_bank0_local: assert property (REQ && REQ_ADDR >= MRD_BANK0_BASE
		&& REQ_ADDR < MRD_BANK0_BASE + MRD_KB16
		|=> RSP_VALID && !FWD_VALID && RSP_ERROR == PARITY_ERR)
		else $error("bank 0 not served locally");
	a_gap_error: assert property (REQ && REQ_ADDR >= MRD_BANK0_BASE + MRD_KB16
		&& REQ_ADDR < MRD_BANK3_BASE |=> RSP_ERROR && !FWD_VALID) else $error("gap accepted");
	a_wake_inval: assert property (HIB_WAKE |=> CACHE_INVALID)
		else $error("wake left cache valid");
	a_inval_clear: assert property (CACHE_INVALID && !CACHE_EN && !HIB_WAKE
		|=> !CACHE_INVALID) else $error("invalid flag not cleared");
	a_parity_err: assert property (PARITY_ERR |-> RSP_VALID && RSP_ERROR)
		else $error("parity event without error answer");
	// main scenarios
	c_fwd: cover property (REQ ##1 FWD_VALID);
	c_err: cover property (REQ && REQ_DMA ##1 RSP_ERROR);
	c_wake: cover property (HIB_WAKE ##1 CACHE_INVALID);
endmodule : mrd_checker

// ### dv/mrd_master_model.sv
`timescale 1ns/10ps
module mrd_master_model (
	input wire logic   CLK,
	output logic        REQ = 1'b0,
	output logic        REQ_DMA = 1'b0,
	output logic        REQ_WRITE = 1'b0,
	output logic [1:0]  REQ_SIZE = 2'h2,
	output logic [31:0] REQ_ADDR = 32'h0,
	output logic [31:0] REQ_WDATA = 32'h0
);
	// ****************************************************************
	// one access, core or dma, answer settled on return
	// ****************************************************************
	task automatic go(input logic d, w, input logic [1:0] s, input logic [31:0] a, wd);
		@(posedge CLK);
		REQ       <= 1'b1;
		REQ_DMA   <= d;
		REQ_WRITE <= w;
		REQ_SIZE  <= s;
		REQ_ADDR  <= a;
		REQ_WDATA <= wd;
		@(posedge CLK);
		REQ       <= 1'b0;
		// released address and data lines invert so stale values never look valid
		REQ_ADDR  <= ~a;
		REQ_WDATA <= ~wd;
		#1;
	endtask : go
endmodule : mrd_master_model

// ### rtl/mrd_decoder.sv
`timescale 1ns/10ps
// Function
// - code region up to 0x7ffff goes to flash; top 4 KB is key storage
// - instruction/data split only in whole 32 KB granules
// - data SRAM answers in one cycle, no wait states
// - core and DMA both read and write data SRAM
// - byte, half and word sizes; narrow writes touch only addressed bytes
// - instruction SRAM disabled maps its 32 KB as extra data SRAM
// - cache enabled withholds top 4 KB of the isram window as cache storage; the isram-off data alias stays 32 KB
// - optional parity bits per word, generated on write, checked on read
// - hibernate keeps at most 124 KB in one of two layouts
// - cache contents invalid after hibernate wake-up
// - system region handled inside the processor platform
// - private peripheral space lowest 256 KB; core only, DMA refused
// - platform control registers reachable by the core only
// - bank 0 is 16 KB at 0x20000000
// - bank 3 at 0x20040000, bank 4 at 0x20044000, 16 KB each
// - bank 5 32 KB at 0x20048000, bank 6 16 KB at 0x20050000
// - instruction banks form one 32 KB window at 0x10000000
module mrd_decoder #(
	parameter int PAR_BITS = mrd_pkg::MRD_PAR_BITS
) (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        REQ,
	input  wire logic        REQ_DMA,
	input  wire logic        REQ_WRITE,
	input  wire logic [1:0]  REQ_SIZE,
	input  wire logic [31:0] REQ_ADDR,
	input  wire logic [31:0] REQ_WDATA,
	input  wire logic        ISRAM_EN,
	input  wire logic        CACHE_EN,
	input  wire logic        PARITY_EN,
	input  wire logic        HIB_ENTER,
	input  wire logic        HIB_ISRAM_KEEP,
	input  wire logic        HIB_WAKE,
	output logic             RSP_VALID,
	output logic             RSP_ERROR,
	output logic [31:0]      RSP_RDATA,
	output logic             FWD_VALID,
	output logic [3:0]       FWD_TARGET,
	output logic [31:0]      FWD_ADDR,
	output logic             FWD_WRITE,
	output logic [31:0]      FWD_WDATA,
	output logic [3:0]       FWD_STRB,
	output logic             PARITY_ERR,
	output logic             CACHE_INVALID,
	output logic [1:0]       HIB_KEEP_MAP
);
	import mrd_pkg::*;

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	// parity groups are byte lanes, so a word carries one to four bits
	if (PAR_BITS < 1 || PAR_BITS > 4) begin : g_bad_par_bits
		$error("PAR_BITS must be 1 to 4");
	end

	// ****************************************************************
	// map overview
	// ****************************************************************
	// code      0x0000_0000 .. 0x0007_efff  forwarded as flash
	// key       0x0007_f000 .. 0x0007_ffff  forwarded as key storage
	// isram     0x1000_0000 .. 0x1000_7fff  local, only while enabled
	// cache     0x1000_7000 .. 0x1000_7fff  withheld while cache is on
	// bank 0    0x2000_0000 .. 0x2000_3fff  local data sram
	// bank 3-6  0x2004_0000 .. 0x2005_3fff  local data sram, contiguous
	// isram off 0x2005_4000 .. 0x2005_bfff  isram storage seen as data
	// mmr       0x4000_0000 .. 0x4004_ffff  forwarded as peripherals
	// ppb       0xe000_0000 .. 0xe003_ffff  forwarded, core only
	// platform  0xe004_0000 .. 0xe004_0fff  forwarded, core only
	// system    0xe004_1000 .. 0xffff_ffff  forwarded, core only
	// anything else is a gap and is answered locally with an error
	//
	// word index layout of the unified array:
	//   0x0000 .. 0x0fff  bank 0
	//   0x1000 .. 0x5fff  banks 3 to 6
	//   0x6000 .. 0x7fff  instruction sram, or its data alias
	// the isram window and the data alias reach the same words, so
	// switching the isram off keeps its contents visible as data
	//
	// hazards and limits:
	//   the array has no reset; parity is only meaningful for words
	//   written since power-up, so enable checking after an init pass
	//   the cache slice is only hidden from the isram window here; its
	//   storage behaviour belongs to the cache controller
	//   retention layout is only reported, the power switches are
	//   driven elsewhere from the latched code

	// ****************************************************************
	// helpers
	// ****************************************************************
	// byte lanes for an access of given size at given address
	function automatic logic [3:0] mrd_strb(input logic [1:0] sz, input logic [1:0] a);
		logic [3:0] s;
		s = 4'h0;
		case (sz)
			MRD_SZ_BYTE: s = 4'h1 << a;
			MRD_SZ_HALF: s = a[1] ? 4'hc : 4'h3;
			default:     s = 4'hf;
		endcase
		return s;
	endfunction : mrd_strb

	// one parity bit per byte lane, for the lowest PAR_BITS lanes only
	function automatic logic [3:0] mrd_par(input logic [31:0] d);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (i < PAR_BITS) begin
				p[i] = ^d[i*8 +: 8];
			end
		end
		return p;
	endfunction : mrd_par

	function automatic logic mrd_in(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		return (a >= lo) && (a < hi);
	endfunction : mrd_in

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic        rsp_valid;
		logic        rsp_error;
		logic [31:0] rsp_rdata;
		logic        fwd_valid;
		logic [3:0]  fwd_target;
		logic [31:0] fwd_addr;
		logic        fwd_write;
		logic [31:0] fwd_wdata;
		logic [3:0]  fwd_strb;
		logic        parity_err;
		logic        cache_invalid;
		logic [1:0]  hib_keep_map;
	} mrd_state_s;

	mrd_state_s st;
	mrd_state_s next_st;

	// unified sram: word index 0..32767 covers 128 KB, data then isram
	logic [31:0] mem [MRD_SRAM_WORDS];
	logic [3:0]  par [MRD_SRAM_WORDS];

	logic              cacheable_top;
	logic [31:0]       dext_end;
	logic [31:0]       isram_top;
	mrd_target_e       tgt;
	logic              deny;
	logic [14:0]       widx;
	logic              is_sram;
	logic [3:0]        strb;
	logic [31:0]       rd_word;
	logic [3:0]        rd_par;
	logic [31:0]       merged;

	// ****************************************************************
	// address decode
	// ****************************************************************
	// isram window shrinks by the cache slice; disabled isram relocates
	// its 32 KB right after bank 6 as extra data space
	// the decode is a priority chain; the system test overlaps the ppb
	// and platform windows, so those two must be tried before it
	always_comb begin
		cacheable_top = CACHE_EN;
		isram_top = CACHE_EN ? MRD_ISRAM_END - MRD_CACHE_BYTES : MRD_ISRAM_END;
		dext_end  = ISRAM_EN ? MRD_DEXT_BASE : MRD_DEXT_BASE + MRD_KB32;
		tgt  = MRD_T_NONE;
		widx = 15'h0;
		deny = 1'b0;
		if (REQ_ADDR <= MRD_CODE_LAST) begin
			tgt = (REQ_ADDR >= MRD_KEY_BASE) ? MRD_T_KEY : MRD_T_FLASH;
		end else if (ISRAM_EN && mrd_in(REQ_ADDR, MRD_ISRAM_BASE, isram_top)) begin
			tgt  = MRD_T_ISRAM;
			widx = 15'(((REQ_ADDR - MRD_ISRAM_BASE) >> 2) + 32'h0000_6000);
		end else if (mrd_in(REQ_ADDR, MRD_BANK0_BASE, MRD_BANK0_BASE + MRD_KB16)) begin
			tgt  = MRD_T_DSRAM;
			widx = 15'((REQ_ADDR - MRD_BANK0_BASE) >> 2);
		end else if (mrd_in(REQ_ADDR, MRD_BANK3_BASE, dext_end)) begin
			tgt  = MRD_T_DSRAM;
			widx = 15'(((REQ_ADDR - MRD_BANK3_BASE) >> 2) + 32'h0000_1000);
		end else if (mrd_in(REQ_ADDR, MRD_MMR_BASE, MRD_MMR_END)) begin
			tgt = MRD_T_MMR;
		end else if (mrd_in(REQ_ADDR, MRD_SYS_BASE, MRD_PPB_END)) begin
			tgt  = MRD_T_PPB;
			deny = REQ_DMA;
		end else if (mrd_in(REQ_ADDR, MRD_PLAT_BASE, MRD_PLAT_END)) begin
			tgt  = MRD_T_PLAT;
			deny = REQ_DMA;
		end else if (REQ_ADDR >= MRD_SYS_BASE) begin
			tgt  = MRD_T_SYS;
			deny = REQ_DMA;
		end
		is_sram = (tgt == MRD_T_ISRAM) || (tgt == MRD_T_DSRAM);
		strb    = mrd_strb(REQ_SIZE, REQ_ADDR[1:0]);
		rd_word = mem[widx];
		rd_par  = par[widx];
		merged  = rd_word;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merged[i*8 +: 8] = REQ_WDATA[i*8 +: 8];
			end
		end
	end

	// ****************************************************************
	// response and forwarding
	// ****************************************************************
	// sram answered locally next cycle; other regions forwarded outward
	// refused and unmapped accesses never reach the array write below
	// forward fields hold their last value so the far side may look late
	always_comb begin
		next_st = st;
		next_st.rsp_valid  = 1'b0;
		next_st.rsp_error  = 1'b0;
		next_st.fwd_valid  = 1'b0;
		next_st.parity_err = 1'b0;
		if (REQ) begin
			if (tgt == MRD_T_NONE || deny) begin
				next_st.rsp_valid = 1'b1;
				next_st.rsp_error = 1'b1;
				next_st.rsp_rdata = 32'h0;
			end else if (is_sram) begin
				next_st.rsp_valid = 1'b1;
				next_st.rsp_rdata = REQ_WRITE ? 32'h0 : rd_word;
				if (!REQ_WRITE && PARITY_EN && rd_par != mrd_par(rd_word)) begin
					next_st.rsp_error  = 1'b1;
					next_st.parity_err = 1'b1;
				end
			end else begin
				next_st.fwd_valid  = 1'b1;
				next_st.fwd_target = tgt;
				next_st.fwd_addr   = REQ_ADDR;
				next_st.fwd_write  = REQ_WRITE;
				next_st.fwd_wdata  = REQ_WDATA;
				next_st.fwd_strb   = strb;
			end
		end
		// cache storage is not retained; wake marks it invalid until the cache is disabled
		if (HIB_WAKE) begin
			next_st.cache_invalid = 1'b1;
		end else if (!cacheable_top) begin
			next_st.cache_invalid = 1'b0;
		end
		// 2'h1: 124 KB data; 2'h2: 96 KB data plus 28 KB isram
		if (HIB_ENTER) begin
			next_st.hib_keep_map = HIB_ISRAM_KEEP ? 2'h2 : 2'h1;
		end
	end

	// ****************************************************************
	// registers and sram array
	// ****************************************************************
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// arrays carry no reset; writes skipped on any refused access
	always_ff @(posedge CLK) begin
		if (REQ && REQ_WRITE && is_sram && !deny) begin
			mem[widx] <= merged;
			par[widx] <= mrd_par(merged);
		end
	end

	assign RSP_VALID     = st.rsp_valid;
	assign RSP_ERROR     = st.rsp_error;
	assign RSP_RDATA     = st.rsp_rdata;
	assign FWD_VALID     = st.fwd_valid;
	assign FWD_TARGET    = st.fwd_target;
	assign FWD_ADDR      = st.fwd_addr;
	assign FWD_WRITE     = st.fwd_write;
	assign FWD_WDATA     = st.fwd_wdata;
	assign FWD_STRB      = st.fwd_strb;
	assign PARITY_ERR    = st.parity_err;
	assign CACHE_INVALID = st.cache_invalid;
	assign HIB_KEEP_MAP  = st.hib_keep_map;
endmodule : mrd_decoder

// ### rtl/mrd_pkg.sv
package mrd_pkg;
	// ****************************************************************
	// address map
	// ****************************************************************
	localparam logic [31:0] MRD_CODE_BASE   = 32'h0000_0000;
	localparam logic [31:0] MRD_CODE_LAST   = 32'h0007_ffff;
	localparam logic [31:0] MRD_KEY_BASE    = 32'h0007_f000;
	localparam logic [31:0] MRD_ISRAM_BASE  = 32'h1000_0000;
	localparam logic [31:0] MRD_ISRAM_END   = 32'h1000_8000;
	localparam logic [31:0] MRD_BANK0_BASE  = 32'h2000_0000;
	localparam logic [31:0] MRD_BANK3_BASE  = 32'h2004_0000;
	localparam logic [31:0] MRD_BANK4_BASE  = 32'h2004_4000;
	localparam logic [31:0] MRD_BANK5_BASE  = 32'h2004_8000;
	localparam logic [31:0] MRD_BANK6_BASE  = 32'h2005_0000;
	localparam logic [31:0] MRD_DEXT_BASE   = 32'h2005_4000;
	localparam logic [31:0] MRD_SYS_BASE    = 32'he000_0000;
	localparam logic [31:0] MRD_PPB_END     = 32'he004_0000;
	localparam logic [31:0] MRD_PLAT_BASE   = 32'he004_0000;
	localparam logic [31:0] MRD_PLAT_END    = 32'he004_1000;
	localparam logic [31:0] MRD_MMR_BASE    = 32'h4000_0000;
	localparam logic [31:0] MRD_MMR_END     = 32'h4005_0000;
	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam logic [31:0] MRD_KB16        = 32'h0000_4000;
	localparam logic [31:0] MRD_KB32        = 32'h0000_8000;
	localparam logic [31:0] MRD_CACHE_BYTES = 32'h0000_1000;
	localparam int          MRD_PAR_BITS    = 4;
	localparam int          MRD_SRAM_WORDS  = 32768;
	// ****************************************************************
	// targets and sizes of an access
	// ****************************************************************
	typedef enum logic [3:0] {
		MRD_T_NONE, MRD_T_FLASH, MRD_T_KEY, MRD_T_ISRAM, MRD_T_DSRAM,
		MRD_T_MMR, MRD_T_PPB, MRD_T_PLAT, MRD_T_SYS
	} mrd_target_e;
	localparam logic [1:0] MRD_SZ_BYTE = 2'h0;
	localparam logic [1:0] MRD_SZ_HALF = 2'h1;
	localparam logic [1:0] MRD_SZ_WORD = 2'h2;
endpackage : mrd_pkg
